// ---- hw/thermal_defines.svh ----
// register offsets, field positions, reset values and timing counts of the thermal control bank
`ifndef THERMAL_DEFINES_SVH
`define THERMAL_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_ZONE12_SPIKE_SMOOTHING 8'hC2
`define OFS_LUT12_HYST_MIN_DUTY 8'hC3
`define OFS_LUT34_HYST_MIN_DUTY 8'hC4
`define OFS_GENERAL_OUTPUT_PULL_LOW 8'hC5
`define OFS_PROCESSOR_HOT_FORCE_CONTROL 8'hC6
`define OFS_PROCESSOR_HOT_MONITOR_INTERVAL 8'hC7

// ****************************************************************
// reset values
// ****************************************************************
`define RST_ZONE12_SPIKE_SMOOTHING 8'h00
`define RST_LUT12_HYST_MIN_DUTY 8'h00
`define RST_LUT34_HYST_MIN_DUTY 8'h00
`define RST_GENERAL_OUTPUT_PULL_LOW 8'h00
`define RST_PROCESSOR_HOT_FORCE_CONTROL 8'h00
`define RST_PROCESSOR_HOT_MONITOR_INTERVAL 8'h11

// ****************************************************************
// field positions
// ****************************************************************
`define ZONE1_WINDOW_LSB 0
`define ZONE1_USE_BIT 3
`define ZONE2_WINDOW_LSB 4
`define ZONE2_USE_BIT 7
`define HYST_LSB 0
`define MIN_DUTY_LSB 4
`define DUTY_SEL_LSB 0
`define CPU1_SUPPRESS_BIT 4
`define CPU2_SUPPRESS_BIT 5
`define CPU1_FORCE_BIT 6
`define CPU2_FORCE_BIT 7
`define CPU1_INTERVAL_LSB 0
`define CPU2_INTERVAL_LSB 4
`define INTERVAL_LAST_CODE 4'h9
`define MIN_DUTY_LAST_CODE 4'hC

// ****************************************************************
// timing
// ****************************************************************
`define CLOCK_HZ 25000000
`define THROTTLE_TICK_HZ 22500
`define THROTTLE_TICK_CYCLES (`CLOCK_HZ / `THROTTLE_TICK_HZ)
`define THROTTLE_PERIOD_TICKS 80
`define THROTTLE_STEP_TICKS 5
`define FILTER_FRAC_BITS 8

`endif

// ---- hw/thermal_pkg.sv ----
// shared types of the thermal control bank
`default_nettype none

package thermal_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] nibble_t;
    typedef logic [2:0] window_t;
    typedef logic [15:0] filter_acc_t;
endpackage : thermal_pkg

`default_nettype wire

// ---- hw/thermal_fan_throttle_regs.sv ----
// thermal smoothing, table hysteresis, pull-low outputs and forced processor-hot throttling
// Function
// - zone 1 window code bits 2:0 sets smoothing length, code 0 longest, 7 shortest
// - zone 2 window code bits 6:4, same encoding, independent of zone 1
// - use bit 3 or 7 selects filtered temperature for limits and fan control
// - raw reading always unfiltered; filtered value readable even with use bit clear
// - smoothing acts on converted samples, after converter averaging
// - bits 3:0 give table pair a hysteresis, resolution from fine step bit 4
// - bits 3:0 give table pair b hysteresis, resolution from fine step bit 5
// - bits 7:4 give minimum duty below base temperature; 13 codes valid
// - pull-low bit one drives pin low, zero leaves pin undriven
// - throttle waveform period is 80 ticks of the 22.5 kHz clock
// - asserted time is (duty code + 1) times 5 ticks
// - force bits 6 and 7 drive cpu1 and cpu2 hot lines with waveform
// - suppress bits 4 and 5 stop regulator-hot inputs asserting hot lines
// - with hot lines tied both lines drive together on either force bit
// - interval nibbles select monitor window, codes 0 to 9, A to F reserved
// - fine step bit set means hysteresis counts in half degree steps
`default_nettype none
`include "thermal_defines.svh"

module thermal_fan_throttle_regs
    import thermal_pkg::*;
#(
    parameter int TEMP_W = 8,
    parameter int TICK_CYCLES = `THROTTLE_TICK_CYCLES // clocks per throttle tick
) (
    input wire logic CLOCK_IN, // 25 MHz
    input wire logic RSTN_IN, // async reset, active low
    input wire logic [7:0] REG_ADDR_IN, // register offset from serial engine
    input wire logic REG_WR_IN, // write strobe, one cycle
    input wire logic [7:0] REG_WDATA_IN, // write data
    input wire logic REG_RD_IN, // read strobe, one cycle
    output logic [7:0] REG_RDATA_OUT, // read data, valid cycle after strobe
    input wire logic TABLE_PAIR_A_FINE_STEP_IN, // half degree steps for tables 1/2
    input wire logic TABLE_PAIR_B_FINE_STEP_IN, // half degree steps for tables 3/4
    input wire logic HOT_LINES_TIED_IN, // both hot pins shorted together
    input wire logic TEMP_SAMPLE_IN, // pulse: new converted zone samples
    input wire logic [TEMP_W-1:0] ZONE1_TEMP_IN, // converted zone 1 temperature
    input wire logic [TEMP_W-1:0] ZONE2_TEMP_IN, // converted zone 2 temperature
    output logic [TEMP_W-1:0] ZONE1_RAW_OUT, // unfiltered zone 1 reading
    output logic [TEMP_W-1:0] ZONE2_RAW_OUT, // unfiltered zone 2 reading
    output logic [TEMP_W-1:0] ZONE1_FILTERED_OUT, // smoothed zone 1
    output logic [TEMP_W-1:0] ZONE2_FILTERED_OUT, // smoothed zone 2
    output logic [TEMP_W-1:0] ZONE1_CONTROL_TEMP_OUT, // zone 1 for limits and fans
    output logic [TEMP_W-1:0] ZONE2_CONTROL_TEMP_OUT, // zone 2 for limits and fans
    output logic [4:0] TABLE_PAIR_A_HYST_HALF_OUT, // hysteresis in half degrees
    output logic [4:0] TABLE_PAIR_B_HYST_HALF_OUT, // hysteresis in half degrees
    output logic [3:0] TABLE_PAIR_A_MIN_DUTY_OUT, // minimum duty code
    output logic [3:0] TABLE_PAIR_B_MIN_DUTY_OUT, // minimum duty code
    output logic TABLE_PAIR_A_MIN_DUTY_VALID_OUT, // code maps to a duty
    output logic TABLE_PAIR_B_MIN_DUTY_VALID_OUT, // code maps to a duty
    output logic [7:0] GPIO_OUT, // pin drive level, always low
    output logic [7:0] GPIO_OE_OUT, // high while pulling pin low
    input wire logic CPU1_REGULATOR_HOT_IN, // regulator hot, processor 1
    input wire logic CPU2_REGULATOR_HOT_IN, // regulator hot, processor 2
    output logic CPU1_HOT_LINE_OUT, // open-drain level, always low
    output logic CPU1_HOT_LINE_OE_OUT, // high while hot line asserted
    output logic CPU2_HOT_LINE_OUT, // open-drain level, always low
    output logic CPU2_HOT_LINE_OE_OUT, // high while hot line asserted
    output logic [3:0] CPU1_MONITOR_INTERVAL_OUT, // monitor window code
    output logic [3:0] CPU2_MONITOR_INTERVAL_OUT, // monitor window code
    output logic CPU1_INTERVAL_RESERVED_OUT, // code A to F selected
    output logic CPU2_INTERVAL_RESERVED_OUT // code A to F selected
);

    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [6:0] PERIOD_LAST = 7'(`THROTTLE_PERIOD_TICKS - 1);

    // ****************************************************************
    // register file
    // ****************************************************************
    reg_byte_t smooth_r, smooth_nxt;
    reg_byte_t lut12_r, lut12_nxt;
    reg_byte_t lut34_r, lut34_nxt;
    reg_byte_t pull_low_r, pull_low_nxt;
    reg_byte_t hot_ctl_r, hot_ctl_nxt;
    reg_byte_t interval_r, interval_nxt;
    reg_byte_t rdata_r, rdata_nxt;

    always_comb begin
        smooth_nxt = smooth_r;
        lut12_nxt = lut12_r;
        lut34_nxt = lut34_r;
        pull_low_nxt = pull_low_r;
        hot_ctl_nxt = hot_ctl_r;
        interval_nxt = interval_r;
        rdata_nxt = rdata_r;
        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                `OFS_ZONE12_SPIKE_SMOOTHING: smooth_nxt = REG_WDATA_IN;
                `OFS_LUT12_HYST_MIN_DUTY: lut12_nxt = REG_WDATA_IN;
                `OFS_LUT34_HYST_MIN_DUTY: lut34_nxt = REG_WDATA_IN;
                `OFS_GENERAL_OUTPUT_PULL_LOW: pull_low_nxt = REG_WDATA_IN;
                `OFS_PROCESSOR_HOT_FORCE_CONTROL: hot_ctl_nxt = REG_WDATA_IN;
                `OFS_PROCESSOR_HOT_MONITOR_INTERVAL: interval_nxt = REG_WDATA_IN;
                default: ;
            endcase
        end
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                `OFS_ZONE12_SPIKE_SMOOTHING: rdata_nxt = smooth_r;
                `OFS_LUT12_HYST_MIN_DUTY: rdata_nxt = lut12_r;
                `OFS_LUT34_HYST_MIN_DUTY: rdata_nxt = lut34_r;
                `OFS_GENERAL_OUTPUT_PULL_LOW: rdata_nxt = pull_low_r;
                `OFS_PROCESSOR_HOT_FORCE_CONTROL: rdata_nxt = hot_ctl_r;
                `OFS_PROCESSOR_HOT_MONITOR_INTERVAL: rdata_nxt = interval_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            smooth_r <= `RST_ZONE12_SPIKE_SMOOTHING;
            lut12_r <= `RST_LUT12_HYST_MIN_DUTY;
            lut34_r <= `RST_LUT34_HYST_MIN_DUTY;
            pull_low_r <= `RST_GENERAL_OUTPUT_PULL_LOW;
            hot_ctl_r <= `RST_PROCESSOR_HOT_FORCE_CONTROL;
            interval_r <= `RST_PROCESSOR_HOT_MONITOR_INTERVAL;
            rdata_r <= 8'h00;
        end else begin
            smooth_r <= smooth_nxt;
            lut12_r <= lut12_nxt;
            lut34_r <= lut34_nxt;
            pull_low_r <= pull_low_nxt;
            hot_ctl_r <= hot_ctl_nxt;
            interval_r <= interval_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA_OUT = rdata_r;

    // ****************************************************************
    // spike smoothing, one filter per zone
    // ****************************************************************
    logic [TEMP_W-1:0] temp_in [2];
    logic [TEMP_W-1:0] raw_r [2];
    logic [TEMP_W-1:0] filt_out [2];
    logic [TEMP_W-1:0] ctl_out [2];
    logic zone_use [2];
    window_t zone_win [2];

    assign temp_in[0] = ZONE1_TEMP_IN;
    assign temp_in[1] = ZONE2_TEMP_IN;
    assign zone_win[0] = smooth_r[`ZONE1_WINDOW_LSB +: 3];
    assign zone_win[1] = smooth_r[`ZONE2_WINDOW_LSB +: 3];
    assign zone_use[0] = smooth_r[`ZONE1_USE_BIT];
    assign zone_use[1] = smooth_r[`ZONE2_USE_BIT];

    localparam int ACC_W = TEMP_W + `FILTER_FRAC_BITS;

    for (genvar z = 0; z < 2; z++) begin : g_zone
        logic [ACC_W-1:0] acc_r, acc_nxt;
        logic [TEMP_W-1:0] raw_nxt;
        logic signed [ACC_W:0] diff;
        logic [3:0] shift;
        always_comb begin
            // longer window code 0 decays slowest; code 7 still averages two samples
            shift = 4'(4'h8 - {1'b0, zone_win[z]});
            diff = $signed({1'b0, temp_in[z], `FILTER_FRAC_BITS'(0)}) - $signed({1'b0, acc_r});
            acc_nxt = acc_r;
            raw_nxt = raw_r[z];
            if (TEMP_SAMPLE_IN) begin
                // filter sees only finished conversions, so it stacks on converter averaging
                acc_nxt = ACC_W'($signed({1'b0, acc_r}) + (diff >>> shift));
                raw_nxt = temp_in[z];
            end
        end
        always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
                acc_r <= '0;
                raw_r[z] <= '0;
            end else begin
                acc_r <= acc_nxt;
                raw_r[z] <= raw_nxt;
            end
        end
        assign filt_out[z] = acc_r[ACC_W-1 -: TEMP_W];
        assign ctl_out[z] = zone_use[z] ? filt_out[z] : raw_r[z];
    end

    assign ZONE1_RAW_OUT = raw_r[0];
    assign ZONE2_RAW_OUT = raw_r[1];
    assign ZONE1_FILTERED_OUT = filt_out[0];
    assign ZONE2_FILTERED_OUT = filt_out[1];
    assign ZONE1_CONTROL_TEMP_OUT = ctl_out[0];
    assign ZONE2_CONTROL_TEMP_OUT = ctl_out[1];

    // ****************************************************************
    // table hysteresis and minimum duty
    // ****************************************************************
    nibble_t hyst_a, hyst_b;
    assign hyst_a = lut12_r[`HYST_LSB +: 4];
    assign hyst_b = lut34_r[`HYST_LSB +: 4];
    // coarse step is one degree, i.e. two half degrees
    assign TABLE_PAIR_A_HYST_HALF_OUT = TABLE_PAIR_A_FINE_STEP_IN ? {1'b0, hyst_a}
                                                                  : {hyst_a, 1'b0};
    assign TABLE_PAIR_B_HYST_HALF_OUT = TABLE_PAIR_B_FINE_STEP_IN ? {1'b0, hyst_b}
                                                                  : {hyst_b, 1'b0};
    assign TABLE_PAIR_A_MIN_DUTY_OUT = lut12_r[`MIN_DUTY_LSB +: 4];
    assign TABLE_PAIR_B_MIN_DUTY_OUT = lut34_r[`MIN_DUTY_LSB +: 4];
    assign TABLE_PAIR_A_MIN_DUTY_VALID_OUT = lut12_r[`MIN_DUTY_LSB +: 4] <= `MIN_DUTY_LAST_CODE;
    assign TABLE_PAIR_B_MIN_DUTY_VALID_OUT = lut34_r[`MIN_DUTY_LSB +: 4] <= `MIN_DUTY_LAST_CODE;

    // ****************************************************************
    // open-drain general outputs
    // ****************************************************************
    assign GPIO_OUT = 8'h00;
    assign GPIO_OE_OUT = pull_low_r;

    // ****************************************************************
    // forced throttle waveform
    // ****************************************************************
    logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
    logic [6:0] phase_r, phase_nxt;
    logic tick;
    logic [6:0] on_ticks;
    logic wave;
    logic force1, force2, reg_hot1, reg_hot2, drive1, drive2;
    logic hot1_r, hot2_r, hot1_nxt, hot2_nxt;

    assign tick = (tick_cnt_r == TICK_LAST);
    // free-running phase is not restarted by force toggles, so the first period after one can be partial
    always_comb begin
        tick_cnt_nxt = tick ? '0 : TICK_W'(tick_cnt_r + 1'b1);
        phase_nxt = phase_r;
        if (tick) begin
            phase_nxt = (phase_r == PERIOD_LAST) ? 7'h00 : 7'(phase_r + 7'h01);
        end
    end

    assign on_ticks = 7'(({3'h0, hot_ctl_r[`DUTY_SEL_LSB +: 4]} + 7'h01)
                         * 7'(`THROTTLE_STEP_TICKS));
    assign wave = (phase_r < on_ticks);
    assign force1 = hot_ctl_r[`CPU1_FORCE_BIT];
    assign force2 = hot_ctl_r[`CPU2_FORCE_BIT];
    assign reg_hot1 = CPU1_REGULATOR_HOT_IN & ~hot_ctl_r[`CPU1_SUPPRESS_BIT];
    assign reg_hot2 = CPU2_REGULATOR_HOT_IN & ~hot_ctl_r[`CPU2_SUPPRESS_BIT];

    always_comb begin
        drive1 = (force1 & wave) | reg_hot1;
        drive2 = (force2 & wave) | reg_hot2;
        if (HOT_LINES_TIED_IN) begin
            drive1 = drive1 | drive2;
            drive2 = drive1;
        end
        hot1_nxt = drive1;
        hot2_nxt = drive2;
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            tick_cnt_r <= '0;
            phase_r <= 7'h00;
            hot1_r <= 1'b0;
            hot2_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            phase_r <= phase_nxt;
            hot1_r <= hot1_nxt;
            hot2_r <= hot2_nxt;
        end
    end

    assign CPU1_HOT_LINE_OUT = 1'b0;
    assign CPU2_HOT_LINE_OUT = 1'b0;
    assign CPU1_HOT_LINE_OE_OUT = hot1_r;
    assign CPU2_HOT_LINE_OE_OUT = hot2_r;

    // ****************************************************************
    // monitor intervals
    // ****************************************************************
    // a change mid-measurement is not guarded here; software waits for sleep states
    assign CPU1_MONITOR_INTERVAL_OUT = interval_r[`CPU1_INTERVAL_LSB +: 4];
    assign CPU2_MONITOR_INTERVAL_OUT = interval_r[`CPU2_INTERVAL_LSB +: 4];
    assign CPU1_INTERVAL_RESERVED_OUT = interval_r[`CPU1_INTERVAL_LSB +: 4] > `INTERVAL_LAST_CODE;
    assign CPU2_INTERVAL_RESERVED_OUT = interval_r[`CPU2_INTERVAL_LSB +: 4] > `INTERVAL_LAST_CODE;

endmodule : thermal_fan_throttle_regs

`default_nettype wire

// ---- tb/board_pullup_model.sv ----
// board side of the open-drain pins: pull-ups resolve the wired levels
`default_nettype none

module board_pullup_model (
    input wire logic [7:0] gpio_drv_in, // level driven by the block
    input wire logic [7:0] gpio_oe_in, // block pulls the pin
    input wire logic [1:0] hot_drv_in, // hot line drive levels
    input wire logic [1:0] hot_oe_in, // hot line enables
    output logic [7:0] gpio_pin_out, // resolved pin levels
    output logic [1:0] hot_pin_out // resolved hot line levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin must read high, never the last driven value
    assign gpio_pin_out = (gpio_oe_in & gpio_drv_in) | ~gpio_oe_in;
    assign hot_pin_out = (hot_oe_in & hot_drv_in) | ~hot_oe_in;
endmodule : board_pullup_model

`default_nettype wire

// ---- tb/thermal_fan_throttle_regs_properties.sv ----
// concurrent checks on the thermal control bank ports
`default_nettype none
`include "thermal_defines.svh"

module thermal_checker #(
    parameter int TEMP_W = 8
) (
    input wire logic CLOCK_IN, // clock
    input wire logic RSTN_IN, // reset
    input wire logic [7:0] REG_ADDR_IN, // offset
    input wire logic REG_WR_IN, // write
    input wire logic [7:0] REG_WDATA_IN, // data
    input wire logic TABLE_PAIR_A_FINE_STEP_IN, // fine step
    input wire logic HOT_LINES_TIED_IN, // tied
    input wire logic TEMP_SAMPLE_IN, // sample
    input wire logic [TEMP_W-1:0] ZONE1_TEMP_IN, // temp
    input wire logic [TEMP_W-1:0] ZONE1_RAW_OUT, // raw
    input wire logic [TEMP_W-1:0] ZONE1_FILTERED_OUT, // filtered
    input wire logic [TEMP_W-1:0] ZONE1_CONTROL_TEMP_OUT, // control
    input wire logic [4:0] TABLE_PAIR_A_HYST_HALF_OUT, // hysteresis
    input wire logic [3:0] TABLE_PAIR_A_MIN_DUTY_OUT, // min duty
    input wire logic TABLE_PAIR_A_MIN_DUTY_VALID_OUT, // valid
    input wire logic [7:0] GPIO_OUT, // pin level
    input wire logic [7:0] GPIO_OE_OUT, // pin enable
    input wire logic CPU1_REGULATOR_HOT_IN, // vr hot 1
    input wire logic CPU2_REGULATOR_HOT_IN, // vr hot 2
    input wire logic CPU1_HOT_LINE_OUT, // level 1
    input wire logic CPU1_HOT_LINE_OE_OUT, // enable 1
    input wire logic CPU2_HOT_LINE_OE_OUT, // enable 2
    input wire logic [3:0] CPU1_MONITOR_INTERVAL_OUT, // interval
    input wire logic CPU1_INTERVAL_RESERVED_OUT // reserved
);
    timeunit 1ns;
    timeprecision 1ps;
    // shadow of the bank, indexed by the low offset bits
    logic [7:0] sh_r [8];
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sh_r <= '{7: `RST_PROCESSOR_HOT_MONITOR_INTERVAL, default: 8'h00};
        end else if (REG_WR_IN && REG_ADDR_IN inside {[8'hC2:8'hC7]}) begin
            sh_r[REG_ADDR_IN[2:0]] <= REG_WDATA_IN;
        end
    end
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    // two cycles, since the hot enables are registered after the register write
    sequence s_cpu1_quiet;
        (!sh_r[6][6] && !HOT_LINES_TIED_IN && (sh_r[6][4] || !CPU1_REGULATOR_HOT_IN))[*2];
    endsequence
    sequence s_cpu1_full;
        (sh_r[6][6] && sh_r[6][3:0] == 4'hF)[*2];
    endsequence
    sequence s_cpu2_vr_hot;
        (CPU2_REGULATOR_HOT_IN && !sh_r[6][5])[*2];
    endsequence
    AST_PINS_PULL_LOW_ONLY: assert property (GPIO_OUT == 8'h00 && !CPU1_HOT_LINE_OUT)
        else $error("open-drain level not low");
    AST_PULL_LOW_WRITE: assert property (REG_WR_IN && REG_ADDR_IN == 8'hC5
        |=> GPIO_OE_OUT == $past(REG_WDATA_IN)) else $error("pin enable not written byte");
    AST_RAW_TRACKS: assert property (TEMP_SAMPLE_IN |=> ZONE1_RAW_OUT == $past(ZONE1_TEMP_IN))
        else $error("raw reading not last sample");
    AST_CONTROL_SELECT: assert property (ZONE1_CONTROL_TEMP_OUT ==
        (sh_r[2][3] ? ZONE1_FILTERED_OUT : ZONE1_RAW_OUT)) else $error("wrong control source");
    AST_FILTER_ON_SAMPLES: assert property (!TEMP_SAMPLE_IN |=> $stable(ZONE1_FILTERED_OUT))
        else $error("filter moved without a sample");
    AST_HYST_SCALE: assert property (TABLE_PAIR_A_HYST_HALF_OUT == (TABLE_PAIR_A_FINE_STEP_IN ?
        {1'b0, sh_r[3][3:0]} : {sh_r[3][3:0], 1'b0})) else $error("hysteresis scale wrong");
    AST_MIN_DUTY_CODES: assert property (TABLE_PAIR_A_MIN_DUTY_OUT == sh_r[3][7:4] &&
        TABLE_PAIR_A_MIN_DUTY_VALID_OUT == (sh_r[3][7:4] <= 4'hC)) else $error("min duty wrong");
    AST_INTERVAL_CODES: assert property (CPU1_MONITOR_INTERVAL_OUT == sh_r[7][3:0] &&
        CPU1_INTERVAL_RESERVED_OUT == (sh_r[7][3:0] > 4'h9)) else $error("interval code wrong");
    AST_VR_HOT_PASSES: assert property (s_cpu2_vr_hot |-> CPU2_HOT_LINE_OE_OUT)
        else $error("regulator hot not passed");
    AST_RELEASED: assert property (s_cpu1_quiet |-> !CPU1_HOT_LINE_OE_OUT)
        else $error("hot line held without a source");
    AST_TIED_TOGETHER: assert property (HOT_LINES_TIED_IN [*2] |->
        CPU1_HOT_LINE_OE_OUT == CPU2_HOT_LINE_OE_OUT) else $error("tied lines differ");
    AST_FULL_DUTY: assert property (s_cpu1_full |-> CPU1_HOT_LINE_OE_OUT)
        else $error("full duty dropped");
endmodule : thermal_checker

bind thermal_fan_throttle_regs thermal_checker #(.TEMP_W(TEMP_W)) u_checker (.*);

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the thermal control bank
`default_nettype none
`include "thermal_defines.svh"

module testbench;
    import thermal_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK_IN = 1'b0, RSTN_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0, rd_taken = 1'b0;
    logic TABLE_PAIR_A_FINE_STEP_IN = 1'b0, TABLE_PAIR_B_FINE_STEP_IN = 1'b0;
    logic HOT_LINES_TIED_IN = 1'b0, TEMP_SAMPLE_IN = 1'b0;
    logic CPU1_REGULATOR_HOT_IN = 1'b0, CPU2_REGULATOR_HOT_IN = 1'b0;
    logic [7:0] REG_ADDR_IN = 8'h00, REG_WDATA_IN = 8'h00;
    logic [7:0] ZONE1_TEMP_IN = 8'h00, ZONE2_TEMP_IN = 8'h00, REG_RDATA_OUT, GPIO_OUT;
    logic [7:0] ZONE1_RAW_OUT, ZONE2_RAW_OUT, ZONE1_FILTERED_OUT, ZONE2_FILTERED_OUT;
    logic [7:0] ZONE1_CONTROL_TEMP_OUT, ZONE2_CONTROL_TEMP_OUT, GPIO_OE_OUT, gpio_pin;
    logic [4:0] TABLE_PAIR_A_HYST_HALF_OUT, TABLE_PAIR_B_HYST_HALF_OUT;
    logic [3:0] TABLE_PAIR_A_MIN_DUTY_OUT, TABLE_PAIR_B_MIN_DUTY_OUT;
    logic [3:0] CPU1_MONITOR_INTERVAL_OUT, CPU2_MONITOR_INTERVAL_OUT;
    logic TABLE_PAIR_A_MIN_DUTY_VALID_OUT, TABLE_PAIR_B_MIN_DUTY_VALID_OUT;
    logic CPU1_HOT_LINE_OUT, CPU1_HOT_LINE_OE_OUT, CPU2_HOT_LINE_OUT, CPU2_HOT_LINE_OE_OUT;
    logic CPU1_INTERVAL_RESERVED_OUT, CPU2_INTERVAL_RESERVED_OUT;
    logic [1:0] hot_pin;
    reg_byte_t exp_q[$];
    int err_count = 0, num_checks = 0, acc1 = 0, acc2 = 0;
    always #20 CLOCK_IN = ~CLOCK_IN;
    // short tick keeps whole throttle periods inside the cycle budget
    localparam int TICK_CYC = 100;
    thermal_fan_throttle_regs #(.TEMP_W(8), .TICK_CYCLES(TICK_CYC)) u_dut (.*);
    board_pullup_model u_board (.gpio_drv_in(GPIO_OUT), .gpio_oe_in(GPIO_OE_OUT),
        .hot_drv_in({CPU2_HOT_LINE_OUT, CPU1_HOT_LINE_OUT}),
        .hot_oe_in({CPU2_HOT_LINE_OE_OUT, CPU1_HOT_LINE_OE_OUT}),
        .gpio_pin_out(gpio_pin), .hot_pin_out(hot_pin));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK_IN);
        REG_ADDR_IN <= a;
        REG_WDATA_IN <= d;
        REG_WR_IN <= 1'b1;
        @(posedge CLOCK_IN);
        REG_WR_IN <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge CLOCK_IN);
        REG_ADDR_IN <= a;
        REG_RD_IN <= 1'b1;
        @(posedge CLOCK_IN);
        REG_RD_IN <= 1'b0;
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge CLOCK_IN);
        @(negedge CLOCK_IN);
    endtask : settle
    // bounded: a full throttle period is 8000 clocks
    task automatic wait_hot1(input logic lvl);
        int n;
        n = 0;
        while (CPU1_HOT_LINE_OE_OUT !== lvl) begin
            @(negedge CLOCK_IN);
            n++;
            if (n > 9000) begin
                err_count++;
                end_sim();
            end
        end
    endtask : wait_hot1
    always @(posedge CLOCK_IN) rd_taken <= REG_RD_IN;
    always @(negedge CLOCK_IN) begin
        if (rd_taken) begin
            check(REG_RDATA_OUT, exp_q.pop_front());
        end
    end
    initial begin
        reg_byte_t v;
        logic [4:0] ha;
        logic [4:0] hb;
        longint t0;
        void'($urandom(83));
        repeat (2) @(posedge CLOCK_IN);
        RSTN_IN <= 1'b1;
        for (int i = 2; i < 8; i++) rd(8'(8'hC0 + i), (i == 7) ? 8'h11 : 8'h00);
        wr(8'hC8, 8'hA5);
        rd(8'hC8, 8'h00);
        // phase runs from reset, so forcing now starts a period
        wr(8'hC6, 8'h40);
        v = 8'($urandom());
        wr(8'hC5, v);
        rd(8'hC5, v);
        @(negedge CLOCK_IN);
        check({GPIO_OE_OUT, gpio_pin}, {v, ~v});
        wr(8'hC5, 8'h00);
        @(negedge CLOCK_IN);
        check(gpio_pin, 8'hFF);
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom_range(15, 1));
            wr(8'hC3, {4'(i), v[3:0]});
            wr(8'hC4, {4'(15 - i), v[3:0]});
            wr(8'hC7, {4'(15 - i), 4'(i)});
            TABLE_PAIR_A_FINE_STEP_IN <= i[0];
            TABLE_PAIR_B_FINE_STEP_IN <= ~i[0];
            ha = i[0] ? {1'b0, v[3:0]} : {v[3:0], 1'b0};
            hb = i[0] ? {v[3:0], 1'b0} : {1'b0, v[3:0]};
            @(negedge CLOCK_IN);
            check({TABLE_PAIR_A_HYST_HALF_OUT, TABLE_PAIR_B_HYST_HALF_OUT}, {ha, hb});
            check({TABLE_PAIR_A_MIN_DUTY_VALID_OUT, TABLE_PAIR_A_MIN_DUTY_OUT,
                TABLE_PAIR_B_MIN_DUTY_VALID_OUT, TABLE_PAIR_B_MIN_DUTY_OUT},
                {i <= 12, 4'(i), 15 - i <= 12, 4'(15 - i)});
            check({CPU2_INTERVAL_RESERVED_OUT, CPU2_MONITOR_INTERVAL_OUT,
                CPU1_INTERVAL_RESERVED_OUT, CPU1_MONITOR_INTERVAL_OUT},
                {15 - i > 9, 4'(15 - i), i > 9, 4'(i)});
        end
        rd(8'hC7, 8'h0F);
        wr(8'hC2, 8'h0F);
        for (int k = 1; k < 4; k++) begin
            @(posedge CLOCK_IN);
            ZONE1_TEMP_IN <= 8'(k * 40);
            ZONE2_TEMP_IN <= 8'(k * 50);
            TEMP_SAMPLE_IN <= 1'b1;
            acc1 = acc1 + ((k * 40 * 256 - acc1) >>> 1);
            acc2 = acc2 + ((k * 50 * 256 - acc2) >>> 8);
            @(posedge CLOCK_IN);
            TEMP_SAMPLE_IN <= 1'b0;
            @(negedge CLOCK_IN);
            check({ZONE1_FILTERED_OUT, ZONE1_CONTROL_TEMP_OUT}, {8'(acc1 >> 8), 8'(acc1 >> 8)});
            check({ZONE2_FILTERED_OUT, ZONE2_CONTROL_TEMP_OUT}, {8'(acc2 >> 8), 8'(k * 50)});
        end
        wr(8'hC2, 8'h80);
        @(negedge CLOCK_IN);
        check({ZONE1_CONTROL_TEMP_OUT, ZONE1_FILTERED_OUT}, {8'd120, 8'(acc1 >> 8)});
        check(ZONE2_CONTROL_TEMP_OUT, 8'(acc2 >> 8));
        @(posedge CLOCK_IN);
        CPU2_REGULATOR_HOT_IN <= 1'b1;
        settle();
        check({CPU2_HOT_LINE_OE_OUT, hot_pin}, 3'b100);
        wr(8'hC6, 8'h60);
        settle();
        check(CPU2_HOT_LINE_OE_OUT, 1'b0);
        @(posedge CLOCK_IN);
        HOT_LINES_TIED_IN <= 1'b1;
        settle();
        check(CPU2_HOT_LINE_OE_OUT, 1'b1);
        @(posedge CLOCK_IN);
        HOT_LINES_TIED_IN <= 1'b0;
        CPU2_REGULATOR_HOT_IN <= 1'b0;
        wait_hot1(1'b0);
        for (int d = 1; d < 4; d++) begin
            wr(8'hC6, 8'(8'h40 + d));
            // first pulse is cut short by the free-running phase; time the next whole one
            wait_hot1(1'b1);
            wait_hot1(1'b0);
            wait_hot1(1'b1);
            t0 = $time;
            wait_hot1(1'b0);
            check(32'(($time - t0) / 40), (d + 1) * `THROTTLE_STEP_TICKS * TICK_CYC);
        end
        t0 = $time;
        wr(8'hC6, 8'h4F);
        settle();
        check(CPU1_HOT_LINE_OE_OUT, 1'b1);
        wr(8'hC6, 8'h43);
        wait_hot1(1'b0);
        wait_hot1(1'b1);
        check(32'(($time - t0) / 40), (`THROTTLE_PERIOD_TICKS - 20) * TICK_CYC);
        wr(8'hC6, 8'h10);
        @(posedge CLOCK_IN);
        CPU1_REGULATOR_HOT_IN <= 1'b1;
        settle();
        check({CPU1_HOT_LINE_OE_OUT, hot_pin}, 3'b011);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
